// File: verilog/opoc_ctrl.sv
// 1+1 changeover controller: sequencer, retry timer, apb registers and interrupt
`timescale 1ns/1ps
module opoc_ctrl #(
    parameter int unsigned RETRY_TICKS  = opoc_pkg::RETRY_TICKS,
    parameter int unsigned PRESCALE_CYC = opoc_pkg::PRESCALE_CYC,
    parameter int unsigned STEP_CYC     = opoc_pkg::STEP_CYC,
    parameter int unsigned SETTLE_CYC   = opoc_pkg::SETTLE_CYC
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   main_health,
    input  wire logic                   rf_present,
    input  wire logic                   remote_reset,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output opoc_pkg::opoc_drive_t       drive,
    output opoc_pkg::opoc_status_t      status,
    output logic                        irq
);
    logic                         health_db;
    logic                         rf_db;
    logic                         remote_db;
    logic                         remote_prev;
    logic                         auto_mode;
    logic                         rf_source;
    logic                         retrying;
    logic                         main_faulty;
    logic                         main_fail;
    logic                         manual_reset;
    logic                         sw_reset;
    logic                         apb_wr;
    logic                         apb_rd;
    logic [3:0]                   irq_stat;
    logic [3:0]                   irq_mask;
    logic [3:0]                   irq_ev;
    logic [31:0]                  step_cnt;
    logic [31:0]                  pre_cnt;
    logic [31:0]                  tick_cnt;
    logic                         to_reserve;
    opoc_pkg::opoc_state_t        state;
    opoc_pkg::opoc_state_t        next_state;
    logic [31:0]                  next_step_cnt;
    logic [31:0]                  next_pre_cnt;
    logic [31:0]                  next_tick_cnt;
    logic                         next_to_reserve;
    logic                         next_retrying;
    logic                         next_main_faulty;
    logic                         next_on_reserve_flag;
    logic                         on_reserve_flag;
    logic [3:0]                   next_irq_stat;
    logic [3:0]                   next_irq_mask;
    logic                         next_auto_mode;
    logic                         next_rf_source;
    logic [31:0]                  next_prdata;
    logic [31:0]                  guard_cnt;
    logic [31:0]                  next_guard_cnt;

    // debounce on every pin input; health filters rest at good so reset shows no false failure
    opoc_debounce #(.CYCLES(opoc_pkg::DEBOUNCE_CYC), .IDLE(1'b1)) u_db_health (
        .clock (clock), .rst_n (rst_n), .raw (main_health), .clean (health_db));
    opoc_debounce #(.CYCLES(opoc_pkg::DEBOUNCE_CYC), .IDLE(1'b1)) u_db_rf (
        .clock (clock), .rst_n (rst_n), .raw (rf_present), .clean (rf_db));
    opoc_debounce #(.CYCLES(opoc_pkg::DEBOUNCE_CYC)) u_db_remote (
        .clock (clock), .rst_n (rst_n), .raw (remote_reset), .clean (remote_db));

    assign main_fail = (guard_cnt == 32'h0) && (rf_source ? !rf_db : !health_db);

    // apb strobes: zero wait state slave
    assign apb_wr   = psel && penable && pwrite;
    assign apb_rd   = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign sw_reset = apb_wr && (paddr == opoc_pkg::ADDR_CTRL) && pwdata[opoc_pkg::CTRL_RESET_BIT];

    // remote reset rising edge acts as manual reset
    assign manual_reset = sw_reset || (remote_db && !remote_prev);

    // sequencer and retry timer
    always_comb
    begin
        next_state           = state;
        next_step_cnt        = step_cnt;
        next_pre_cnt         = pre_cnt;
        next_tick_cnt        = tick_cnt;
        next_to_reserve      = to_reserve;
        next_retrying        = retrying;
        next_main_faulty     = main_faulty;
        next_on_reserve_flag = on_reserve_flag;
        // stale filtered inputs from the unpowered main are blanked after arrival
        next_guard_cnt       = (state != opoc_pkg::OPOC_ON_MAIN) ? opoc_pkg::GUARD_CYC :
                               (guard_cnt != 32'h0) ? guard_cnt - 32'h1 : 32'h0;
        irq_ev               = 4'h0;
        unique case (state)
            opoc_pkg::OPOC_ON_MAIN:
            begin
                // main failure starts changeover to reserve
                if (main_fail)
                begin
                    next_state      = opoc_pkg::OPOC_PWR_OFF;
                    next_to_reserve = 1'b1;
                    next_step_cnt   = '0;
                    irq_ev[opoc_pkg::IRQ_CHANGEOVER] = 1'b1;
                    // a retried main that fails again is recorded faulty
                    if (retrying)
                    begin
                        next_main_faulty = 1'b1;
                        next_retrying    = 1'b0;
                        irq_ev[opoc_pkg::IRQ_MAIN_FAULTY] = 1'b1;
                    end
                end
                // retried main healthy past settle: isolated incident
                else if (retrying && step_cnt == SETTLE_CYC - 1)
                begin
                    next_retrying = 1'b0;
                    irq_ev[opoc_pkg::IRQ_RETRY_OK] = 1'b1;
                end
                else if (retrying)
                    next_step_cnt = step_cnt + 1;
            end
            // fixed order of steps, each STEP_CYC long
            // no new changeover until the sequence completes
            opoc_pkg::OPOC_PWR_OFF, opoc_pkg::OPOC_RELAY, opoc_pkg::OPOC_MPX:
            begin
                if (step_cnt == STEP_CYC - 1)
                begin
                    next_step_cnt = '0;
                    next_state    = opoc_pkg::opoc_state_t'(state + 4'h1);
                    if (state == opoc_pkg::OPOC_PWR_OFF) // relay moves in its own step, ahead of the mpx feed
                        next_on_reserve_flag = to_reserve;
                end
                else
                    next_step_cnt = step_cnt + 1;
            end
            opoc_pkg::OPOC_PWR_ON:
            begin
                if (step_cnt == STEP_CYC - 1)
                begin
                    next_step_cnt = '0;
                    next_pre_cnt  = '0;
                    next_tick_cnt = '0;
                    next_state    = to_reserve ? opoc_pkg::OPOC_ON_RESERVE : opoc_pkg::OPOC_ON_MAIN;
                end
                else
                    next_step_cnt = step_cnt + 1;
            end
            opoc_pkg::OPOC_ON_RESERVE:
            begin
                // main failures ignored while on reserve
                // prescaled five-minute retry timer in auto mode
                // manual mode waits for manual or remote reset
                if (manual_reset || (auto_mode && !main_faulty && tick_cnt == RETRY_TICKS - 1
                                     && pre_cnt == PRESCALE_CYC - 1))
                begin
                    next_state       = opoc_pkg::OPOC_PWR_OFF;
                    next_to_reserve  = 1'b0;
                    next_retrying    = !manual_reset;
                    next_main_faulty = manual_reset ? 1'b0 : main_faulty;
                    next_step_cnt    = '0;
                    irq_ev[opoc_pkg::IRQ_SWITCHBACK] = 1'b1;
                end
                else if (auto_mode && !main_faulty)
                begin
                    // retry interval counted in prescaler ticks
                    if (pre_cnt == PRESCALE_CYC - 1)
                    begin
                        next_pre_cnt  = '0;
                        next_tick_cnt = tick_cnt + 1;
                    end
                    else
                        next_pre_cnt = pre_cnt + 1;
                end
            end
            default:
                next_state = opoc_pkg::OPOC_ON_MAIN;
        endcase
    end

    // reset state: main powered, relay at rest on main
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state           <= opoc_pkg::OPOC_ON_MAIN;
            step_cnt        <= '0;
            pre_cnt         <= '0;
            tick_cnt        <= '0;
            to_reserve      <= 1'b0;
            retrying        <= 1'b0;
            main_faulty     <= 1'b0;
            on_reserve_flag <= 1'b0;
            remote_prev     <= 1'b0;
            guard_cnt       <= opoc_pkg::GUARD_CYC;
        end
        else
        begin
            state           <= next_state;
            step_cnt        <= next_step_cnt;
            pre_cnt         <= next_pre_cnt;
            tick_cnt        <= next_tick_cnt;
            to_reserve      <= next_to_reserve;
            retrying        <= next_retrying;
            main_faulty     <= next_main_faulty;
            on_reserve_flag <= next_on_reserve_flag;
            remote_prev     <= remote_db;
            guard_cnt       <= next_guard_cnt;
        end
    end

    // outputs decoded from state, relay from its registered flag; all high-level drives select main in idle
    always_comb
    begin
        drive.interlock     = (state != opoc_pkg::OPOC_ON_MAIN) && (state != opoc_pkg::OPOC_ON_RESERVE);
        drive.relay_reserve = on_reserve_flag;
        drive.mpx_reserve   = (state == opoc_pkg::OPOC_ON_RESERVE) ||
                              ((state == opoc_pkg::OPOC_MPX || state == opoc_pkg::OPOC_PWR_ON) && to_reserve) ||
                              ((state == opoc_pkg::OPOC_PWR_OFF || state == opoc_pkg::OPOC_RELAY) && !to_reserve);
        // power removed from both units between off and on steps
        drive.power_main    = (state == opoc_pkg::OPOC_ON_MAIN) ||
                              (state == opoc_pkg::OPOC_PWR_ON && !to_reserve);
        drive.power_reserve = (state == opoc_pkg::OPOC_ON_RESERVE) ||
                              (state == opoc_pkg::OPOC_PWR_ON && to_reserve);
        status.on_reserve    = on_reserve_flag;
        status.switching     = drive.interlock;
        status.retry_pending = (state == opoc_pkg::OPOC_ON_RESERVE) && auto_mode && !main_faulty;
        status.main_faulty   = main_faulty;
    end

    // registers: set wins over write-one clear
    always_comb
    begin
        next_auto_mode = auto_mode;
        next_rf_source = rf_source;
        next_irq_mask  = irq_mask;
        next_irq_stat  = irq_stat;
        next_prdata    = prdata;
        if (apb_wr && paddr == opoc_pkg::ADDR_CTRL)
        begin
            next_auto_mode = pwdata[opoc_pkg::CTRL_AUTO_BIT];
            next_rf_source = pwdata[opoc_pkg::CTRL_RF_SRC_BIT];
        end
        if (apb_wr && paddr == opoc_pkg::ADDR_IRQ_MASK)
            next_irq_mask = pwdata[3:0];
        if (apb_wr && paddr == opoc_pkg::ADDR_IRQ_STAT)
            next_irq_stat = irq_stat & ~pwdata[3:0];
        next_irq_stat = next_irq_stat | irq_ev;
        if (apb_rd)
        begin
            unique case (paddr)
                opoc_pkg::ADDR_CTRL:     next_prdata = {30'h0, rf_source, auto_mode};
                opoc_pkg::ADDR_STATUS:   next_prdata = {24'h0, state, status};
                opoc_pkg::ADDR_IRQ_STAT: next_prdata = {28'h0, irq_stat};
                opoc_pkg::ADDR_IRQ_MASK: next_prdata = {28'h0, irq_mask};
                default:                 next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_mode <= opoc_pkg::CTRL_RESET_VAL[opoc_pkg::CTRL_AUTO_BIT];
            rf_source <= opoc_pkg::CTRL_RESET_VAL[opoc_pkg::CTRL_RF_SRC_BIT];
            irq_mask  <= opoc_pkg::IRQ_MASK_RESET;
            irq_stat  <= 4'h0;
            prdata    <= 32'h0;
        end
        else
        begin
            auto_mode <= next_auto_mode;
            rf_source <= next_rf_source;
            irq_mask  <= next_irq_mask;
            irq_stat  <= next_irq_stat;
            prdata    <= next_prdata;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // interlock stays high through every step
    a_interlock_held: assert property (@(posedge clock) disable iff (!rst_n)
        (state != opoc_pkg::OPOC_ON_MAIN && state != opoc_pkg::OPOC_ON_RESERVE) |-> drive.interlock)
        else $error("interlock low during switching");
    // relay only moves while both units unpowered
    a_relay_cold: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(drive.relay_reserve) |-> !drive.power_main && !drive.power_reserve && drive.interlock)
        else $error("relay moved hot");
    // failure on main starts changeover next cycle
    a_fail_starts: assert property (@(posedge clock) disable iff (!rst_n)
        (state == opoc_pkg::OPOC_ON_MAIN && main_fail) |=> state == opoc_pkg::OPOC_PWR_OFF)
        else $error("failure not acted on");
    // idle on main means main powered and connected
    a_main_idle: assert property (@(posedge clock) disable iff (!rst_n)
        state == opoc_pkg::OPOC_ON_MAIN |-> drive.power_main && !drive.relay_reserve)
        else $error("main not selected");
    // second failure while retrying latches fault
    a_fault_latch: assert property (@(posedge clock) disable iff (!rst_n)
        (state == opoc_pkg::OPOC_ON_MAIN && retrying && main_fail) |=> main_faulty)
        else $error("fault not latched");
    // no switch-back in manual mode without reset
    a_manual_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (state == opoc_pkg::OPOC_ON_RESERVE && !auto_mode && !manual_reset) |=> state == opoc_pkg::OPOC_ON_RESERVE)
        else $error("manual mode retried");
    a_reserve_ignore: assert property (@(posedge clock) disable iff (!rst_n)
        (state == opoc_pkg::OPOC_ON_RESERVE && main_faulty && !manual_reset) |=> state == opoc_pkg::OPOC_ON_RESERVE)
        else $error("left reserve after fault");
    // once raised, interlock stays high for at least eight cycles in any sequence
    a_step_length: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(drive.interlock) |-> drive.interlock[*8])
        else $error("sequence cut short");
endmodule

// File: verilog/opoc_pkg.sv
// package: constants, states and status carriers for the 1+1 changeover controller
package opoc_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned RETRY_S           = 300;                 // five minutes
    localparam int unsigned PRESCALE_MS       = 1;                   // prescaler tick period in ms
    localparam int unsigned PRESCALE_CYC      = CLK_HZ / 1000 * PRESCALE_MS;
    localparam int unsigned RETRY_TICKS       = RETRY_S * 1000 / PRESCALE_MS;
    localparam int unsigned DEBOUNCE_CYC      = 16;
    localparam int unsigned GUARD_CYC         = DEBOUNCE_CYC + 4;    // failure blanking on arrival at main
    localparam int unsigned STEP_US           = 2000;                // each switching step, 2 ms
    localparam int unsigned STEP_CYC          = CLK_HZ / 1_000_000 * STEP_US;
    localparam int unsigned SETTLE_US         = 50_000;              // health settle after power restore
    localparam int unsigned SETTLE_CYC        = CLK_HZ / 1_000_000 * SETTLE_US;

    // apb register map
    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h0C;

    // control register fields
    localparam int unsigned CTRL_AUTO_BIT     = 0;                   // 1 = automatic retry mode
    localparam int unsigned CTRL_RF_SRC_BIT   = 1;                   // 1 = failure from rf detector
    localparam int unsigned CTRL_RESET_BIT    = 2;                   // write 1: manual reset pulse
    localparam logic [1:0]  CTRL_RESET_VAL    = 2'h1;                // auto mode, equipment fault source

    // interrupt bits
    localparam int unsigned IRQ_W             = 4;
    localparam int unsigned IRQ_CHANGEOVER    = 0;
    localparam int unsigned IRQ_SWITCHBACK    = 1;
    localparam int unsigned IRQ_MAIN_FAULTY   = 2;
    localparam int unsigned IRQ_RETRY_OK      = 3;
    localparam logic [3:0]  IRQ_MASK_RESET    = 4'h0;

    typedef enum logic [3:0] {
        OPOC_ON_MAIN    = 4'h0,
        OPOC_PWR_OFF    = 4'h1,
        OPOC_RELAY      = 4'h2,
        OPOC_MPX        = 4'h3,
        OPOC_PWR_ON     = 4'h4,
        OPOC_ON_RESERVE = 4'h5,
        OPOC_SETTLE     = 4'h6
    } opoc_state_t;

    // per-unit drive bundle
    typedef struct packed {
        logic power_main;     // 1 = main unit powered
        logic power_reserve;  // 1 = reserve unit powered
        logic relay_reserve;  // 1 = coax relay to reserve (0 = rest position, main)
        logic mpx_reserve;    // 1 = mpx feed to reserve
        logic interlock;      // 1 = rf outputs blocked
    } opoc_drive_t;

    // remote status bundle
    typedef struct packed {
        logic on_reserve;
        logic switching;
        logic retry_pending;
        logic main_faulty;
    } opoc_status_t;

endpackage

// File: verilog/opoc_debounce.sv
// two-flop synchroniser followed by a stable-count debounce filter
`timescale 1ns/1ps
module opoc_debounce #(
    parameter int unsigned CYCLES = 16,
    parameter logic        IDLE   = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      clean
);
    logic                        sync_a;
    logic                        sync_b;
    logic [$clog2(CYCLES+1)-1:0] cnt;
    logic [$clog2(CYCLES+1)-1:0] next_cnt;
    logic                        next_clean;

    // sync_a is read only by sync_b
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a <= IDLE;
            sync_b <= IDLE;
        end
        else
        begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    // output follows only after the input has held for CYCLES clocks
    always_comb
    begin
        next_cnt   = cnt;
        next_clean = clean;
        if (sync_b == clean)
            next_cnt = '0;
        else if (cnt == ($clog2(CYCLES+1))'(CYCLES - 1))
        begin
            next_cnt   = '0;
            next_clean = sync_b;
        end
        else
            next_cnt = cnt + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt   <= '0;
            clean <= IDLE;
        end
        else
        begin
            cnt   <= next_cnt;
            clean <= next_clean;
        end
    end
endmodule

// File: test/opoc_exciter_model.sv
// behavioural model of the main exciter as seen by the changeover controller
`timescale 1ns/1ps
module opoc_exciter_model (
    input  wire logic                  fail_health,
    input  wire logic                  fail_rf,
    input  wire opoc_pkg::opoc_drive_t drive,
    output logic                       main_health,
    output logic                       rf_present
);
    // health only while powered
    // health stays low while unpowered, so a dead unit never looks good
    assign main_health = drive.power_main & ~fail_health;
    assign rf_present  = drive.power_main & ~drive.interlock & ~fail_rf;
endmodule

// File: test/opoc_ctrl_tb.sv
// self-checking bench for the 1+1 changeover controller
`timescale 1ns/1ps
module opoc_ctrl_tb;
    localparam logic [4:0] D_MAIN = 5'h10;
    localparam logic [4:0] D_RES  = 5'h0E;
    logic                   clock = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   fail_health = 1'b0;
    logic                   fail_rf = 1'b0;
    logic                   remote_reset = 1'b0;
    logic                   main_health;
    logic                   rf_present;
    logic                   irq;
    logic [31:0]            rd;
    opoc_pkg::opoc_drive_t  drive;
    opoc_pkg::opoc_status_t status;
    int                     n_mismatch = 0;
    int                     check_count = 0;

    // short counts keep the run brief; retry span is 10 ticks of 4 cycles
    // settle span must outlast the failure blanking on arrival at main
    opoc_ctrl #(.RETRY_TICKS(10), .PRESCALE_CYC(4), .STEP_CYC(4), .SETTLE_CYC(40)) i_opoc_ctrl (
        .clock(clock), .rst_n(rst_n), .main_health(main_health), .rf_present(rf_present),
        .remote_reset(remote_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive),
        .status(status), .irq(irq));
    opoc_exciter_model i_opoc_exciter_model (
        .fail_health(fail_health), .fail_rf(fail_rf), .drive(drive),
        .main_health(main_health), .rf_present(rf_present));

    // free-running system clock
    always #5 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so callers see what the transfer launched
        @(posedge clock);
    endtask

    // outputs sampled on the falling edge, away from the update edge
    task automatic wait_drive(input logic [4:0] want);
        int n;
        n = 0;
        @(negedge clock);
        while (drive !== want && n < 300)
        begin
            @(negedge clock);
            n++;
        end
        check({27'h0, drive}, {27'h0, want});
        // hand back on a rising edge so the next stimulus change lands there
        @(posedge clock);
    endtask

    task automatic hold(input int cyc);
        repeat (cyc) @(posedge clock);
    endtask

    task automatic go_reserve();
        wait_drive(5'h01);
        wait_drive(5'h05);
        wait_drive(5'h07);
        wait_drive(D_RES);
    endtask

    task automatic go_main();
        wait_drive(5'h07);
        wait_drive(5'h03);
        wait_drive(5'h01);
        wait_drive(D_MAIN);
    endtask

    task automatic t_reset();
        check({27'h0, drive}, {27'h0, D_MAIN});
        check({28'h0, status}, 32'h0);
        apb(1'b0, opoc_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h00000001);
        check({30'h0, pready, pslverr}, 32'h00000002);
        apb(1'b0, opoc_pkg::ADDR_IRQ_MASK, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_auto();
        // a glitch shorter than the filter must not trip a changeover
        fail_health <= 1'b1;
        hold(5);
        fail_health <= 1'b0;
        hold(60);
        check({27'h0, drive}, {27'h0, D_MAIN});
        fail_health <= 1'b1;
        go_reserve();
        check({31'h0, status.on_reserve}, 32'h1);
        check({28'h0, status}, 32'h0000000A);
        check({31'h0, irq}, 32'h0);
        fail_health <= 1'b0;
        apb(1'b1, opoc_pkg::ADDR_IRQ_MASK, 32'h00000001);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, opoc_pkg::ADDR_IRQ_STAT, 32'h00000001);
        hold(1);
        check({31'h0, irq}, 32'h0);
        go_main();
        hold(60);
        check({27'h0, drive}, {27'h0, D_MAIN});
        check({31'h0, status.main_faulty}, 32'h0);
        apb(1'b0, opoc_pkg::ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h0000000A);
        $display("test auto retry done");
    endtask

    task automatic t_twice();
        fail_health <= 1'b1;
        go_reserve();
        go_main();
        go_reserve();
        hold(200);
        check({27'h0, drive}, {27'h0, D_RES});
        check({31'h0, status.main_faulty}, 32'h1);
        check({28'h0, status}, 32'h00000009);
        fail_health <= 1'b0;
        remote_reset <= 1'b1;
        go_main();
        remote_reset <= 1'b0;
        check({31'h0, status.main_faulty}, 32'h0);
        $display("test permanent fault done");
    endtask

    task automatic t_manual();
        apb(1'b1, opoc_pkg::ADDR_CTRL, 32'h0);
        fail_health <= 1'b1;
        go_reserve();
        fail_health <= 1'b0;
        hold(200);
        check({27'h0, drive}, {27'h0, D_RES});
        apb(1'b1, opoc_pkg::ADDR_CTRL, 32'h00000004);
        go_main();
        $display("test manual mode done");
    endtask

    task automatic t_rf();
        apb(1'b1, opoc_pkg::ADDR_CTRL, 32'h00000003);
        fail_health <= 1'b1;
        hold(60);
        check({27'h0, drive}, {27'h0, D_MAIN});
        fail_health <= 1'b0;
        fail_rf <= 1'b1;
        go_reserve();
        fail_rf <= 1'b0;
        rst_n <= 1'b0;
        hold(2);
        check({27'h0, drive}, {27'h0, D_MAIN});
        rst_n <= 1'b1;
        $display("test rf source done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the whole sequence needs about a thousand cycles
    initial
    begin
        hold(20000);
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        hold(6);
        rst_n <= 1'b1;
        hold(1);
        t_reset();
        t_auto();
        t_twice();
        t_manual();
        t_rf();
        hold(5);
        end_of_test();
    end
endmodule
